// file: pkg/flash_status_pkg.sv
// constants shared by the flash status host controller
package flash_status_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 100;
    localparam int WE_PULSE_NS = 50;
    localparam int SELECT_HIGH_NS = 20;
    localparam int SYNC_STAGES = 2;
    // least times round up, never below one cycle
    localparam int ACCESS_CYC_RAW = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;
    localparam int WE_CYC_RAW = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYC = (WE_CYC_RAW < 1) ? 1 : WE_CYC_RAW;
    localparam int HIGH_CYC_RAW = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC = (HIGH_CYC_RAW < 1) ? 1 : HIGH_CYC_RAW;

    // ------------------------------------------------------------
    // software register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;

    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_STATUS = 3'h3;
    localparam logic [2:0] OP_STAT_POLL = 3'h4;
    localparam logic [2:0] OP_TOGGLE_POLL = 3'h5;

    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_DONE_BIT = 1;
    localparam int STATE_FAIL_BIT = 2;
    localparam int STATE_LIMIT_BIT = 3;

    // ------------------------------------------------------------
    // operation_status word and polling word of the flash
    // ------------------------------------------------------------
    localparam int IDLE_FLAG_BIT = 7;
    localparam int ERASE_PAUSED_BIT = 6;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int PROGRAM_FAIL_BIT = 4;
    localparam int BUFFER_ABORT_BIT = 3;
    localparam int PROGRAM_PAUSED_BIT = 2;
    localparam int LOCKED_FAIL_BIT = 1;
    localparam logic [15:0] STATUS_MASK = 16'h00fe;
    localparam logic [15:0] RESULT_MASK = 16'h007e;

    localparam int POLARITY_POLL_BIT = 7;
    localparam int TOGGLE_ONE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int ERASE_STARTED_BIT = 3;
    localparam int TOGGLE_TWO_BIT = 2;
    localparam int ABORT_BIT = 1;
    localparam logic [15:0] POLL_MASK = 16'h00ee;

endpackage

// file: pkg/flash_cycle_if.sv
// one flash bus cycle request and its completion
`timescale 1ns/10ps
interface flash_cycle_if #(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16
) ();
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;

    modport master (output req, output wr, output addr, output wdata,
                    input rdata, input done);
    modport target (input req, input wr, input addr, input wdata,
                    output rdata, output done);
endinterface

// file: src/status_decode.sv
// masks raw flash words into usable status and polling bits
`timescale 1ns/10ps
module status_decode (
    input wire logic [15:0] raw_i,
    output logic [7:0] status_o,
    output logic [7:0] poll_o
);
    wire logic [15:0] status_kept;
    wire logic idle_now;

    // reserved bits may change between reads, so never pass them on
    assign status_kept = raw_i & flash_status_pkg::STATUS_MASK;
    assign idle_now = raw_i[flash_status_pkg::IDLE_FLAG_BIT];
    // bits 6..1 only mean something once the flash is idle
    assign status_o = idle_now ? status_kept[7:0]
                               : (status_kept[7:0] & ~flash_status_pkg::RESULT_MASK[7:0]);
    assign poll_o = raw_i[7:0] & flash_status_pkg::POLL_MASK[7:0];
endmodule

// file: src/flash_bus_cycle.sv
// runs one asynchronous read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle #(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    flash_cycle_if.target cyc,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [DATA_W-1:0] dq_i,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o
);
    localparam int RD_LOW = flash_status_pkg::ACCESS_CYC + flash_status_pkg::SYNC_STAGES;
    localparam logic [7:0] RD_LOW_C = 8'(RD_LOW - 1);
    localparam logic [7:0] WR_LOW_C = 8'(flash_status_pkg::WE_CYC - 1);
    localparam logic [7:0] HIGH_C = 8'(flash_status_pkg::HIGH_CYC - 1);

    if (RD_LOW > 256 || flash_status_pkg::HIGH_CYC > 256) begin : g_bad_timing
        $error("flash_bus_cycle: timing counts exceed counter");
    end

    typedef enum logic [1:0] {B_IDLE, B_LOW, B_HIGH} bus_state_e;

    bus_state_e state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic wr_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [DATA_W-1:0] sync1_reg, sync2_reg;
    logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_reg;
    wire logic cnt_zero;
    wire logic capture;
    wire logic wr_next_w;

    assign cnt_zero = (cnt_reg == 8'h00);
    assign capture = (state_reg == B_LOW) && cnt_zero && !wr_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_zero ? 8'h00 : cnt_reg - 8'h01;
        unique case (state_reg)
            B_IDLE: begin
                if (cyc.req) begin
                    state_next = B_LOW;
                    cnt_next = cyc.wr ? WR_LOW_C : RD_LOW_C;
                end
            end
            B_LOW: begin
                if (cnt_zero) begin
                    state_next = B_HIGH;
                    // strobes stay high this long before the next cycle
                    cnt_next = HIGH_C;
                end
            end
            B_HIGH: begin
                if (cnt_zero) begin
                    state_next = B_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // data input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= dq_i;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= B_IDLE;
            cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
        end else if (state_reg == B_IDLE && cyc.req) begin
            wr_reg <= cyc.wr;
            addr_reg <= cyc.addr;
            wdata_reg <= cyc.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= '0;
        end else if (capture) begin
            rdata_reg <= sync2_reg;
        end
    end

    // strobes come straight from flops to keep them glitch free
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
        end else begin
            ce_n_reg <= (state_next != B_LOW);
            oe_n_reg <= !(state_next == B_LOW && !wr_next_w);
            we_n_reg <= !(state_next == B_LOW && wr_next_w);
            dq_oe_reg <= (state_next == B_LOW && wr_next_w);
        end
    end

    assign wr_next_w = (state_reg == B_IDLE) ? cyc.wr : wr_reg;

    assign addr_o = addr_reg;
    assign dq_o = wdata_reg;
    assign dq_oe_o = dq_oe_reg;
    assign ce_n_o = ce_n_reg;
    assign oe_n_o = oe_n_reg;
    assign we_n_o = we_n_reg;
    assign cyc.rdata = rdata_reg;
    assign cyc.done = (state_reg == B_HIGH) && cnt_zero;
endmodule

// file: src/flash_status_host.sv
// host controller that issues flash cycles and tracks operation status
// Behaviour
// - host holds chip select and output enable high for select_high_time after reads
// - status bits 15:8 and 0 are reserved; host masks them
// - host trusts status bits 6..1 only while idle_flag is 1
// - after a suspend the host rereads status until idle_flag is 1; it gives up after POLL_LIMIT reads and sets the limit flag
// - polling bits 15:8, 4 and 0 are reserved; host masks them
// - buffer programs are polled only at the last loaded word
// - erase drives polarity_poll_bit 0, then 1; host addresses the erasing sector
`timescale 1ns/10ps
module flash_status_host #(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16,
    parameter int POLL_LIMIT = 1024
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic [DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [DATA_W-1:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o
);
    localparam int TRY_W = (POLL_LIMIT > 1) ? $clog2(POLL_LIMIT) : 1;
    localparam logic [TRY_W-1:0] TRY_LAST = TRY_W'(POLL_LIMIT - 1);

    if (DATA_W != 16) begin : g_bad_data
        $error("flash_status_host: data width must be 16");
    end
    if (ADDR_W < 1 || ADDR_W > 31) begin : g_bad_addr
        $error("flash_status_host: address width out of range");
    end
    if (POLL_LIMIT < 1) begin : g_bad_limit
        $error("flash_status_host: poll limit must be positive");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {M_IDLE, M_CMD, M_RD_A, M_RD_B} main_state_e;

    main_state_e state_reg, state_next;
    logic [2:0] op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [15:0] first_reg, first_next;
    logic [TRY_W-1:0] tries_reg, tries_next;
    logic recheck_reg, recheck_next;
    logic pending_reg;
    logic done_reg, fail_reg, limit_reg;
    logic [31:0] rdata_out_reg;
    logic finish, fail_set, limit_set;

    flash_cycle_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

    wire logic is_idle;
    wire logic hit_ctrl, hit_addr, hit_wdata, hit_state, hit_rdata, hit_flags;
    wire logic [2:0] op_w;
    wire logic op_ok;
    wire logic start;
    wire logic [7:0] status_bits;
    wire logic [7:0] poll_bits;
    wire logic word_idle;
    wire logic toggle_still;
    wire logic at_limit;
    wire logic [31:0] state_word;
    wire logic [31:0] read_mux;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign is_idle = (state_reg == M_IDLE);
    assign hit_ctrl = (reg_addr_i == flash_status_pkg::OFS_CTRL);
    assign hit_addr = (reg_addr_i == flash_status_pkg::OFS_ADDR);
    assign hit_wdata = (reg_addr_i == flash_status_pkg::OFS_WDATA);
    assign hit_state = (reg_addr_i == flash_status_pkg::OFS_STATE);
    assign hit_rdata = (reg_addr_i == flash_status_pkg::OFS_RDATA);
    assign hit_flags = (reg_addr_i == flash_status_pkg::OFS_FLAGS);
    assign op_w = reg_wdata_i[2:0];
    assign op_ok = (op_w >= flash_status_pkg::OP_WRITE)
                && (op_w <= flash_status_pkg::OP_TOGGLE_POLL);
    // starts while busy are dropped; software checks busy first
    assign start = reg_wr_i && hit_ctrl && is_idle && op_ok;

    // ------------------------------------------------------------
    // word decode
    // ------------------------------------------------------------
    status_decode u_decode (
        .raw_i(rdata_reg),
        .status_o(status_bits),
        .poll_o(poll_bits)
    );

    assign word_idle = cyc.rdata[flash_status_pkg::IDLE_FLAG_BIT];
    assign toggle_still = cyc.rdata[flash_status_pkg::TOGGLE_ONE_BIT]
                       != first_reg[flash_status_pkg::TOGGLE_ONE_BIT];
    assign at_limit = (tries_reg == TRY_LAST);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        first_next = first_reg;
        tries_next = tries_reg;
        recheck_next = recheck_reg;
        finish = 1'b0;
        fail_set = 1'b0;
        limit_set = 1'b0;
        unique case (state_reg)
            M_IDLE: begin
                if (start) begin
                    tries_next = '0;
                    recheck_next = 1'b0;
                    if (op_w == flash_status_pkg::OP_READ
                        || op_w == flash_status_pkg::OP_TOGGLE_POLL) begin
                        state_next = M_RD_A;
                    end else begin
                        state_next = M_CMD;
                    end
                end
            end
            M_CMD: begin
                if (cyc.done) begin
                    if (op_reg == flash_status_pkg::OP_WRITE) begin
                        finish = 1'b1;
                    end else begin
                        // the single read that follows takes the overlay
                        state_next = M_RD_A;
                    end
                end
            end
            M_RD_A: begin
                if (cyc.done) begin
                    if (op_reg == flash_status_pkg::OP_TOGGLE_POLL) begin
                        first_next = cyc.rdata;
                        state_next = M_RD_B;
                    end else if (op_reg != flash_status_pkg::OP_STAT_POLL || word_idle) begin
                        // one read only: the overlay is gone after it
                        finish = 1'b1;
                    end else if (at_limit) begin
                        finish = 1'b1;
                        limit_set = 1'b1;
                    end else begin
                        // each retry reissues the status command first
                        tries_next = tries_reg + 1'b1;
                        state_next = M_CMD;
                    end
                end
            end
            M_RD_B: begin
                if (cyc.done) begin
                    if (!toggle_still) begin
                        finish = 1'b1;
                    end else if (recheck_reg) begin
                        // still toggling after the timeout showed: failed
                        finish = 1'b1;
                        fail_set = 1'b1;
                    end else if (at_limit) begin
                        finish = 1'b1;
                        limit_set = 1'b1;
                    end else begin
                        // timeout may rise as toggling stops, so look once more
                        recheck_next = cyc.rdata[flash_status_pkg::TIMEOUT_BIT];
                        first_next = cyc.rdata;
                        tries_next = tries_reg + 1'b1;
                    end
                end
            end
        endcase
        if (finish) begin
            state_next = M_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= M_IDLE;
            first_reg <= 16'h0000;
            tries_reg <= '0;
            recheck_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            first_reg <= first_next;
            tries_reg <= tries_next;
            recheck_reg <= recheck_next;
        end
    end

    // ------------------------------------------------------------
    // bus cycle launch
    // ------------------------------------------------------------
    // one request per state visit, one per read while M_RD_B retries; pending blocks a double launch
    assign cyc.req = !is_idle && !pending_reg;
    assign cyc.wr = (state_reg == M_CMD);
    assign cyc.addr = addr_reg;
    assign cyc.wdata = wdata_reg;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending_reg <= 1'b0;
        end else if (cyc.done) begin
            pending_reg <= 1'b0;
        end else if (cyc.req) begin
            pending_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 16'h0000;
        end else if (cyc.done && !cyc.wr) begin
            rdata_reg <= cyc.rdata;
        end
    end

    flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .cyc(cyc),
        .addr_o(flash_addr_o),
        .dq_o(flash_dq_o),
        .dq_oe_o(flash_dq_oe_o),
        .dq_i(flash_dq_i),
        .ce_n_o(flash_ce_n_o),
        .oe_n_o(flash_oe_n_o),
        .we_n_o(flash_we_n_o)
    );

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_reg <= 3'h0;
            addr_reg <= '0;
            wdata_reg <= 16'h0000;
        end else begin
            if (start) begin
                op_reg <= op_w;
            end
            if (reg_wr_i && hit_addr && is_idle) begin
                addr_reg <= reg_wdata_i[ADDR_W-1:0];
            end
            if (reg_wr_i && hit_wdata && is_idle) begin
                wdata_reg <= reg_wdata_i[15:0];
            end
        end
    end

    // a finish never meets a start, so the flags need no priority
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            limit_reg <= 1'b0;
        end else if (start) begin
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            limit_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
            fail_reg <= fail_set;
            limit_reg <= limit_set;
        end
    end

    assign state_word = {28'h0000000, limit_reg, fail_reg, done_reg, !is_idle};
    assign read_mux = hit_ctrl ? {29'h00000000, op_reg}
                    : hit_addr ? 32'(addr_reg)
                    : hit_wdata ? {16'h0000, wdata_reg}
                    : hit_state ? state_word
                    : hit_rdata ? {16'h0000, rdata_reg}
                    : hit_flags ? {16'h0000, poll_bits, status_bits}
                    : 32'h00000000;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_out_reg <= 32'h00000000;
        end else if (reg_rd_i) begin
            rdata_out_reg <= read_mux;
        end else begin
            rdata_out_reg <= 32'h00000000;
        end
    end

    assign reg_rdata_o = rdata_out_reg;
endmodule

// file: tb/flash_model.sv
// behavioural flash answering status and polling reads
`timescale 1ns/10ps
module flash_model (
    input wire logic [25:0] addr_i,
    input wire logic [15:0] wd_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    output logic [15:0] dq_o
);
    int busy = 0;
    logic [7:0] res = 8'h00;
    logic tmo = 1'b0;
    logic ovl = 1'b0;
    logic tog = 1'b0;
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    logic [7:0] junk;
    wire rd_on = !ce_n_i && !oe_n_i;
    // reserved bits change from read to read
    assign junk = ~last[15:8];
    always_comb begin
        if (ovl) word = {junk, busy == 0, res[6:1], ~last[0]};
        else if (busy != 0) word = {junk, 1'b0, tog, tmo, ~last[4], 1'b1, tog, 1'b0,
                                    ~last[0]};
        else word = addr_i[15:0];
    end
    // a released bus never holds the last value
    assign dq_o = rd_on ? word : ~last;
    always @(negedge rd_on) begin
        last = word;
        if (ovl) ovl = 1'b0;
        else if (busy != 0) begin
            tog = ~tog;
            busy--;
        end
    end
    always @(negedge we_n_i) begin
        #1;
        if (wd_i == 16'h0070) ovl = 1'b1;
        if (wd_i == 16'h0071) res &= 8'h44;
        if (wd_i == 16'h00f0) res &= 8'h44;
        if (wd_i == 16'h00f0) tmo = 1'b0;
        if (wd_i == 16'h0030) res[6] = 1'b0;
    end
endmodule

// file: tb/flash_status_host_sva.sv
// assertions on the host controller ports
`timescale 1ns/10ps
module flash_status_host_sva #(
    parameter int ADDR_W = 26
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic flash_dq_oe_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    localparam int RD_LOW = flash_status_pkg::ACCESS_CYC + flash_status_pkg::SYNC_STAGES;
    int rd_low_q;
    // low cycles of the read strobe, counted instead of a long repetition
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_low_q <= 0;
        end else begin
            rd_low_q <= flash_oe_n_o ? 0 : rd_low_q + 1;
        end
    end
    property p_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    property p_unmap; reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 32'h0; endproperty
    property p_ce_hi; $rose(flash_ce_n_o) |-> flash_ce_n_o [*2]; endproperty
    property p_oe_hi; $rose(flash_oe_n_o) |-> flash_oe_n_o [*2]; endproperty
    property p_rd_len;
        (!flash_oe_n_o |-> rd_low_q < RD_LOW) and ($rose(flash_oe_n_o) |-> rd_low_q == RD_LOW);
    endproperty
    property p_we_len; $fell(flash_we_n_o) |-> !flash_we_n_o [*5] ##1 flash_we_n_o; endproperty
    property p_drive; flash_dq_oe_o |-> !flash_we_n_o && flash_oe_n_o; endproperty
    property p_addr; !flash_ce_n_o && !$fell(flash_ce_n_o) |-> $stable(flash_addr_o); endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_ce_hi: assert property (p_ce_hi) else $error("select high too short");
    a_oe_hi: assert property (p_oe_hi) else $error("enable high too short");
    a_rd_len: assert property (p_rd_len) else $error("read low phase length");
    a_we_len: assert property (p_we_len) else $error("write pulse length");
    a_drive: assert property (p_drive) else $error("data driven outside write");
    a_addr: assert property (p_addr) else $error("address moved in cycle");
    c_wr: cover property ($fell(flash_we_n_o));
    c_rd: cover property ($fell(flash_oe_n_o));
    c_flags: cover property (reg_rd_i && reg_addr_i == 8'h14);
endmodule
bind flash_status_host flash_status_host_sva #(.ADDR_W(ADDR_W)) u_sva (.clock_i, .arst_n_i,
    .reg_addr_i, .reg_rd_i, .reg_rdata_o, .flash_addr_o, .flash_dq_oe_o, .flash_ce_n_o,
    .flash_oe_n_o, .flash_we_n_o);

// file: tb/tb.sv
// self-checking bench for the flash status host
`timescale 1ns/10ps
module tb;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o, got;
    logic [25:0] fa, a;
    logic [15:0] fdq, dq_i;
    logic oe, ce_n, oe_n, we_n;
    logic [7:0] eres;
    int errors = 0;
    int compares = 0;
    flash_status_host #(.POLL_LIMIT(4)) dut (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flash_addr_o(fa), .flash_dq_o(fdq),
        .flash_dq_oe_o(oe), .flash_dq_i(dq_i), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
        .flash_we_n_o(we_n));
    flash_model m (.addr_i(fa), .wd_i(fdq), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .dq_o(dq_i));
    initial forever #5 clock_i = ~clock_i;
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge clock_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 got = reg_rdata_o;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // runs one operation, polling the state word until busy drops
    task automatic op(input logic [31:0] o);
        wr(8'h00, o);
        repeat (300) begin
            rd(8'h0c);
            if (got[0] === 1'b0) break;
        end
        if (got[0] !== 1'b0) errors++;
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        void'($urandom(27193));
        eres = $urandom & 8'h7e;
        a = $urandom;
        m.res = eres;
        rd(8'h0c);
        chk("state", 32'h0, got);
        rd(8'h20);
        chk("unmapped", 32'h0, got);
        wr(8'h04, a);
        wr(8'h08, 32'h0070);
        op(3);
        rd(8'h14);
        chk("flags", {24'h0, 8'h80 | eres}, got & 32'hff);
        rd(8'h10);
        chk("raw", {24'h0, 8'h80 | eres}, got & 32'hfe);
        op(2);
        rd(8'h10);
        chk("array", {16'h0, a[15:0]}, got);
        wr(8'h08, 32'h0071);
        op(1);
        eres &= 8'h44;
        wr(8'h08, 32'h0070);
        op(3);
        rd(8'h14);
        chk("cleared", {24'h0, 8'h80 | eres}, got & 32'hff);
        m.busy = 100;
        op(4);
        rd(8'h0c);
        chk("limit", 32'h8, got & 32'h9);
        rd(8'h14);
        chk("busy flags", 32'h0, got & 32'hff);
        m.busy = 3;
        op(5);
        rd(8'h0c);
        chk("toggle state", 32'h2, got & 32'hf);
        rd(8'h10);
        chk("toggle word", {16'h0, a[15:0]}, got);
        m.busy = 100;
        m.tmo = 1'b1;
        op(5);
        rd(8'h0c);
        chk("timeout fail", 32'h6, got & 32'hf);
        wr(8'h08, 32'h00f0);
        op(1);
        op(5);
        rd(8'h0c);
        chk("timeout cleared", 32'ha, got & 32'hf);
        test_done;
    end
endmodule
